// [core/bscr_regs.sv]
// Operation
// - Refresh writes need 32-bit access and key
// - Refresh reads return zero upper half
// - Mode-space access issues SDRAM mode write
// - Idle cycles after acknowledged-device DMA access
// - Method clear: idle only on bus handover
// - Method set: idle also between repeated accesses
// - Bits 31 to 8 read zero
// - Bit 4 always reads one
// - Endian flag captured at power-on reset
// - Endian flag low pin zero, high one
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module bscr_regs
	import bscr_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	input wire logic clock_en,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic [3:0] byte_en,
	input wire logic write_en,
	input wire logic read_en,
	output logic [31:0] rdata,
	// Strap
	input wire logic byte_order_pin,
	// Bus side
	input wire logic dma_single,
	input wire logic dma_ack_done,
	input wire logic next_is_other,
	output logic idle_req,
	output logic [2:0] idle_count,
	output logic sdram_mode_write,
	output logic sdram_mode_area3,
	output logic [15:0] sdram_mode_value,
	output logic little_endian,
	output logic hiz_mem,
	output logic hiz_cnt,
	output logic [15:0] refresh_ctrl_status,
	output logic [15:0] refresh_counter,
	output logic [15:0] refresh_constant
);
	logic [1:0] dma_idle_count;
	logic dma_idle_method;
	logic hiz_mem_q;
	logic hiz_cnt_q;
	logic endian_q;
	logic strap_taken;
	logic key_ok;
	logic [2:0] code_count;
	logic [31:0] next_rdata;

	// Stand-in for the whole-word check; the key guards against stray writes
	assign key_ok = write_en && (byte_en == SIZE_LONG) && (wdata[31:16] == REF_KEY);

	// Caught on the first enabled edge after power-on reset release
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			endian_q <= 1'b0;
			strap_taken <= 1'b0;
		end else if (clock_en && !strap_taken) begin
			endian_q <= byte_order_pin;
			strap_taken <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			dma_idle_count <= IW_RESET;
			dma_idle_method <= 1'b0;
			hiz_mem_q <= 1'b0;
			hiz_cnt_q <= 1'b0;
		end else if (clock_en && write_en && addr == ADDR_COMMON) begin
			dma_idle_count <= wdata[IW_HI_BIT:IW_LO_BIT];
			dma_idle_method <= wdata[IW_METHOD_BIT];
			hiz_mem_q <= wdata[HIZMEM_BIT];
			hiz_cnt_q <= wdata[HIZCNT_BIT];
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			refresh_ctrl_status <= REF_RESET;
			refresh_counter <= REF_RESET;
			refresh_constant <= REF_RESET;
		end else if (clock_en && key_ok) begin
			case (addr)
				ADDR_REF_CSR: refresh_ctrl_status <= wdata[15:0];
				ADDR_REF_CNT: refresh_counter <= wdata[15:0];
				ADDR_REF_CONST: refresh_constant <= wdata[15:0];
				default: ;
			endcase
		end
	end

	// Mode values go to the SDRAM itself; nothing is stored here
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sdram_mode_write <= 1'b0;
			sdram_mode_area3 <= 1'b0;
			sdram_mode_value <= REF_RESET;
		end else if (clock_en) begin
			sdram_mode_write <= (write_en || read_en) &&
				(addr == ADDR_SDRAM_MODE_AREA2 || addr == ADDR_SDRAM_MODE_AREA3);
			sdram_mode_area3 <= (addr == ADDR_SDRAM_MODE_AREA3);
			sdram_mode_value <= wdata[15:0];
		end
	end

	always_comb begin
		case (dma_idle_count)
			2'h0: code_count = IDLE_00;
			2'h1: code_count = IDLE_01;
			2'h2: code_count = IDLE_10;
			default: code_count = IDLE_11;
		endcase
	end

	// Software must finish this setup before touching areas other than 0
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			idle_req <= 1'b0;
			idle_count <= IDLE_00;
		end else if (clock_en) begin
			idle_req <= dma_single && dma_ack_done && (code_count != IDLE_00) &&
				(next_is_other || dma_idle_method);
			idle_count <= code_count;
		end
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (addr)
			ADDR_COMMON: begin
				next_rdata[IW_HI_BIT:IW_LO_BIT] = dma_idle_count;
				next_rdata[IW_METHOD_BIT] = dma_idle_method;
				next_rdata[ONE_BIT] = 1'b1;
				next_rdata[ENDIAN_BIT] = endian_q;
				next_rdata[HIZMEM_BIT] = hiz_mem_q;
				next_rdata[HIZCNT_BIT] = hiz_cnt_q;
			end
			ADDR_REF_CSR: next_rdata = {REF_UPPER_READ, refresh_ctrl_status};
			ADDR_REF_CNT: next_rdata = {REF_UPPER_READ, refresh_counter};
			ADDR_REF_CONST: next_rdata = {REF_UPPER_READ, refresh_constant};
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rdata <= 32'h0000_0000;
		end else if (clock_en) begin
			rdata <= read_en ? next_rdata : 32'h0000_0000;
		end
	end

	assign little_endian = endian_q;
	assign hiz_mem = hiz_mem_q;
	assign hiz_cnt = hiz_cnt_q;


	// Idle insertion in two steps: an acknowledged access ends, then the request follows
	sequence ack_end_s;
		clock_en && dma_single && dma_ack_done && dma_idle_count != 2'h0;
	endsequence
	sequence idle_out_s;
		idle_req && idle_count != IDLE_00;
	endsequence

	ref_key_a: assert property (@(posedge clock) disable iff (!reset_n)
		clock_en && write_en && addr == ADDR_REF_CNT && wdata[31:16] != REF_KEY
		|=> $stable(refresh_counter)) else $error("refresh write without key changed");
	ref_size_a: assert property (@(posedge clock) disable iff (!reset_n)
		clock_en && write_en && addr == ADDR_REF_CONST && byte_en != SIZE_LONG
		|=> $stable(refresh_constant)) else $error("refresh write of wrong size changed");
	ref_upper_a: assert property (@(posedge clock) disable iff (!reset_n)
		clock_en && read_en && addr == ADDR_REF_CSR |=> rdata[31:16] == REF_UPPER_READ)
		else $error("refresh upper half not zero");
	mode_write_a: assert property (@(posedge clock) disable iff (!reset_n)
		clock_en && write_en && addr == ADDR_SDRAM_MODE_AREA2 |=> sdram_mode_write && !sdram_mode_area3)
		else $error("mode write missing");
	mode_read_a: assert property (@(posedge clock) disable iff (!reset_n)
		clock_en && read_en && addr == ADDR_SDRAM_MODE_AREA3 |=> sdram_mode_write && sdram_mode_area3)
		else $error("mode read without area 3 write");
	mode_value_a: assert property (@(posedge clock) disable iff (!reset_n)
		clock_en && write_en && (addr == ADDR_SDRAM_MODE_AREA2 || addr == ADDR_SDRAM_MODE_AREA3)
		|=> sdram_mode_value == $past(wdata[15:0])) else $error("mode value not passed on");
	idle_none_a: assert property (@(posedge clock) disable iff (!reset_n)
		clock_en && dma_idle_count == 2'h0 |=> !idle_req)
		else $error("idle with zero count");
	idle_two_a: assert property (@(posedge clock) disable iff (!reset_n)
		clock_en && dma_idle_count == 2'h2 |=> idle_count == IDLE_10)
		else $error("code 10 not two");
	idle_four_a: assert property (@(posedge clock) disable iff (!reset_n)
		clock_en && dma_idle_count == 2'h3 |=> idle_count == IDLE_11)
		else $error("code 11 not four");
	handover_only_a: assert property (@(posedge clock) disable iff (!reset_n)
		clock_en && !dma_idle_method && !next_is_other |=> !idle_req)
		else $error("idle without handover");
	handover_idle_a: assert property (@(posedge clock) disable iff (!reset_n)
		ack_end_s ##0 next_is_other |=> idle_out_s)
		else $error("handover idle missing");
	method_set_a: assert property (@(posedge clock) disable iff (!reset_n)
		ack_end_s ##0 dma_idle_method |=> idle_out_s)
		else $error("repeat access idle missing");
	high_zero_a: assert property (@(posedge clock) disable iff (!reset_n)
		$past(clock_en && read_en) && $past(addr) == ADDR_COMMON
		|-> rdata[31:8] == 24'h000000 && rdata[ONE_BIT])
		else $error("common reserved bits wrong");
	strap_catch_a: assert property (@(posedge clock) disable iff (!reset_n)
		clock_en && !strap_taken |=> little_endian == $past(byte_order_pin))
		else $error("endian flag not caught from pin");
	endian_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
		strap_taken |=> $stable(little_endian)) else $error("endian flag changed");

	// A frozen cycle must leave every register as it was
	freeze_a: assert property (@(posedge clock) disable iff (!reset_n)
		!clock_en |=> $stable(refresh_counter) && $stable(dma_idle_count) && $stable(rdata))
		else $error("state moved with clock enable low");
	// Read data stand only in the answer cycle, so a stray sample sees zero
	rdata_idle_a: assert property (@(posedge clock) disable iff (!reset_n)
		clock_en && !read_en |=> rdata == 32'h0000_0000)
		else $error("read data left standing");
endmodule
`default_nettype wire

// [core/bscr_pkg.sv]
package bscr_pkg;
	// Register indices (word addresses on the plain port)
	localparam logic [3:0] ADDR_COMMON = 4'h0;
	localparam logic [3:0] ADDR_REF_CSR = 4'h1;
	localparam logic [3:0] ADDR_REF_CNT = 4'h2;
	localparam logic [3:0] ADDR_REF_CONST = 4'h3;
	localparam logic [3:0] ADDR_SDRAM_MODE_AREA2 = 4'h4;
	localparam logic [3:0] ADDR_SDRAM_MODE_AREA3 = 4'h5;
	// Common control field positions
	localparam int IW_HI_BIT = 7;
	localparam int IW_LO_BIT = 6;
	localparam int IW_METHOD_BIT = 5;
	localparam int ONE_BIT = 4;
	localparam int ENDIAN_BIT = 3;
	localparam int HIZMEM_BIT = 1;
	localparam int HIZCNT_BIT = 0;
	// Protection key in upper half of refresh-register writes
	localparam logic [15:0] REF_KEY = 16'ha55a;
	localparam logic [15:0] REF_UPPER_READ = 16'h0000;
	localparam logic [3:0] SIZE_LONG = 4'hf;
	// Idle counts per field code
	localparam logic [2:0] IDLE_00 = 3'h0;
	localparam logic [2:0] IDLE_01 = 3'h1;
	localparam logic [2:0] IDLE_10 = 3'h2;
	localparam logic [2:0] IDLE_11 = 3'h4;
	localparam logic [1:0] IW_RESET = 2'h0;
	localparam logic [15:0] REF_RESET = 16'h0000;
endpackage

// [bench/bscr_sdram_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Attached SDRAM: holds what the mode writes leave in it
module bscr_sdram_model (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Mode write from the controller
	input wire logic mode_write,
	input wire logic area3,
	input wire logic [15:0] mode_value,
	// Mode registers inside the SDRAM
	output logic [15:0] mode2,
	output logic [15:0] mode3
);
	// Odd preset so that a missed write stays visible
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mode2 <= 16'h5a5a;
			mode3 <= 16'h5a5a;
		end else if (mode_write && !area3) begin
			mode2 <= mode_value;
		end else if (mode_write) begin
			mode3 <= mode_value;
		end
	end
endmodule
`default_nettype wire

// [bench/bscr_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module bscr_regs_tb;
	import bscr_pkg::*;
	logic clock = 0, reset_n = 0, write_en = 0, read_en = 0, pin = 0, le;
	logic dma_single = 0, ack = 0, other = 0, idle_req, mwr, m3, e;
	logic [3:0] addr = 0, byte_en = 0;
	logic [31:0] wdata = 0, rdata, seed = 32'h206357dc, d;
	logic [2:0] idle_count;
	logic [15:0] mval, mode2, mode3;
	logic ce = 1, hm, hc;
	logic [15:0] rcs, rcnt, rcon;
	int fail_count = 0, checked = 0;
	always #50 clock = ~clock;
	bscr_regs u_dut (.clock(clock), .reset_n(reset_n), .clock_en(ce), .addr(addr),
		.wdata(wdata), .byte_en(byte_en), .write_en(write_en), .read_en(read_en),
		.rdata(rdata), .byte_order_pin(pin), .dma_single(dma_single), .dma_ack_done(ack),
		.next_is_other(other), .idle_req(idle_req), .idle_count(idle_count),
		.sdram_mode_write(mwr), .sdram_mode_area3(m3), .sdram_mode_value(mval),
		.little_endian(le), .hiz_mem(hm), .hiz_cnt(hc), .refresh_ctrl_status(rcs),
		.refresh_counter(rcnt), .refresh_constant(rcon));
	bscr_sdram_model u_sdram (.clock(clock), .reset_n(reset_n), .mode_write(mwr),
		.area3(m3), .mode_value(mval), .mode2(mode2), .mode3(mode3));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [2:0] idle_of(input logic [1:0] c);
		return (c == 2'h3) ? 3'h4 : {1'b0, c};
	endfunction
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
		checked++;
		if (s !== x) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] b);
		@(posedge clock);
		write_en <= 1'b1;
		addr <= a;
		wdata <= v;
		byte_en <= b;
		@(posedge clock);
		write_en <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] x);
		@(posedge clock);
		read_en <= 1'b1;
		addr <= a;
		@(posedge clock);
		read_en <= 1'b0;
		#1 chk("rdata", x, rdata);
	endtask
	task automatic wrap_up;
		if (fail_count == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		#2000000 fail_count++;
		wrap_up();
	end
	initial begin
		for (int r = 0; r < 2; r++) begin
			@(posedge clock);
			pin <= r[0];
			reset_n <= 1'b0;
			repeat (4) @(posedge clock);
			reset_n <= 1'b1;
			rd(ADDR_COMMON, 32'h10 | (r << 3));
			pin <= ~pin;
		end
		d = xs(seed);
		seed = d;
		wr(ADDR_COMMON, (d & 32'he3) | 32'h10, 4'hf);
		rd(ADDR_COMMON, (d & 32'he3) | 32'h18);
		chk("endian", 1, le);
		chk("hiz_mem", d[1], hm);
		chk("hiz_cnt", d[0], hc);
		for (int i = 1; i < 4; i++) begin
			d = xs(seed);
			seed = d;
			wr(i[3:0], {REF_KEY, d[15:0]}, 4'hf);
			wr(i[3:0], {REF_KEY ^ 16'h0001, ~d[15:0]}, 4'hf);
			wr(i[3:0], {REF_KEY, ~d[15:0]}, 4'h3);
			rd(i[3:0], {16'h0, d[15:0]});
			chk("refresh", d[15:0], (i == 1) ? rcs : (i == 2) ? rcnt : rcon);
		end
		// A keyed write while frozen must not land
		@(posedge clock);
		ce <= 1'b0;
		wr(ADDR_REF_CONST, {REF_KEY, ~d[15:0]}, 4'hf);
		@(posedge clock);
		ce <= 1'b1;
		rd(ADDR_REF_CONST, {REF_UPPER_READ, d[15:0]});
		for (int i = 4; i < 6; i++) begin
			d = xs(seed);
			seed = d;
			wr(i[3:0], d, 4'hf);
			chk("mode_write", 1, mwr);
			chk("mode_area", i == 5, m3);
			@(posedge clock);
			#1 chk("mode_reg", d[15:0], (i == 4) ? mode2 : mode3);
		end
		rd(ADDR_SDRAM_MODE_AREA3, 32'h0000_0000);
		chk("mode_read", 1, mwr);
		chk("mode_read_area", 1, m3);
		dma_single <= 1'b1;
		for (int k = 0; k < 16; k++) begin
			wr(ADDR_COMMON, {24'h0, k[1:0], k[2], 5'h10}, 4'hf);
			@(posedge clock);
			ack <= 1'b1;
			other <= k[3];
			@(posedge clock);
			ack <= 1'b0;
			e = (k[1:0] != 2'h0) && (k[2] || k[3]);
			#1 chk("idle_req", e, idle_req);
			if (e) chk("idle_count", idle_of(k[1:0]), idle_count);
		end
		wrap_up();
	end
endmodule
`default_nettype wire
